/* File: shared/clm_pkg.sv */
/*
 * Shared constants and types for the configurable logic macrocell array.
 * Assumes one 50 MHz clock, static configuration inputs and a plain register port.
 */
package clm_pkg;

    // ********************************
    // Sizes
    // ********************************
    localparam int N_MC    = 64;
    localparam int N_BLK   = 4;
    localparam int MC_BLK  = 16;
    localparam int N_PT    = 5;
    localparam int N_SW    = 40;
    localparam int N_DED   = 4;
    localparam int N_GCLK  = 3;
    localparam int N_GOE   = 2;
    localparam int N_GBUS  = N_DED + 2 * N_MC;
    localparam int N_LIT   = N_SW + MC_BLK;
    localparam int DATA_W  = 32;
    localparam int ADDR_W  = 8;
    localparam int SIG_W   = 16;

    // Global bus layout: dedicated pins, I/O pins, buried feedback
    localparam int GBUS_IO = N_DED;
    localparam int GBUS_FB = N_DED + N_MC;

    // ********************************
    // Register map
    // ********************************
    localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] REG_SIG      = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STAT     = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STATE_LO = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_STATE_HI = 8'h10;

    localparam int CTRL_KEEP = 0;
    localparam int CTRL_STBY = 1;
    localparam int CTRL_FUSE = 2;
    localparam int STAT_STBY = 0;
    localparam int STAT_FUSE = 1;

    // Arbitrary neutral signature after reset
    localparam logic [SIG_W-1:0] SIG_RESET = 16'h0000;

    // ********************************
    // Configuration encodings
    // ********************************
    typedef enum logic [3:0] {
        PT_NONE = 4'h0, PT_SUM = 4'h1, PT_XOR = 4'h2, PT_DATA = 4'h3,
        PT_AUX  = 4'h4, PT_CLK = 4'h5, PT_CE  = 4'h6, PT_RST  = 4'h7,
        PT_PRE  = 4'h8, PT_OE  = 4'h9
    } clm_pt_dest_t;

    typedef enum logic [1:0] {
        XOR_PT = 2'h0, XOR_ZERO = 2'h1, XOR_ONE = 2'h2
    } clm_xor_sel_t;

    typedef enum logic [1:0] {
        DIN_XOR = 2'h0, DIN_PT = 2'h1, DIN_PIN = 2'h2
    } clm_din_sel_t;

    typedef enum logic [2:0] {
        FF_D = 3'h0, FF_T = 3'h1, FF_JK = 3'h2, FF_SR = 3'h3, FF_LATCH = 3'h4
    } clm_ff_type_t;

    typedef enum logic [1:0] {
        CK_G0 = 2'h0, CK_G1 = 2'h1, CK_G2 = 2'h2, CK_PT = 2'h3
    } clm_clk_sel_t;

    typedef enum logic [1:0] {
        AR_GCLR = 2'h0, AR_PT = 2'h1, AR_OFF = 2'h2, AR_OR = 2'h3
    } clm_ar_sel_t;

    typedef enum logic [2:0] {
        OE_ON = 3'h0, OE_OFF = 3'h1, OE_G0 = 3'h2, OE_G1 = 3'h3,
        OE_PIN = 3'h4, OE_PT = 3'h5
    } clm_oe_sel_t;

    // Per macrocell configuration
    typedef struct packed {
        logic [N_PT-1:0][N_LIT-1:0] lit_pos;
        logic [N_PT-1:0][N_LIT-1:0] lit_neg;
        clm_pt_dest_t [N_PT-1:0]    dest;
        logic [2:0]                 fold_sel;
        logic                       cas_en;
        clm_xor_sel_t               xor_sel;
        clm_din_sel_t               din_sel;
        clm_ff_type_t               ff_type;
        clm_clk_sel_t               clk_sel;
        logic                       ce_en;
        clm_ar_sel_t                ar_sel;
        logic                       ap_en;
        logic                       out_reg;
        logic                       fb_reg;
        clm_oe_sel_t                oe_sel;
        logic [5:0]                 oe_pin;
    } clm_mc_cfg_t;

    // Global routing configuration
    typedef struct packed {
        logic [N_BLK-1:0][N_SW-1:0][7:0] sw_sel;
        logic [N_GCLK-1:0][1:0]          gclk_src;
        logic [1:0]                      clr_src;
        logic [N_GOE-1:0][1:0]           oe_src;
    } clm_glb_cfg_t;

    // Raw pin levels and external drive flags
    typedef struct packed {
        logic [N_DED-1:0] ded_drv;
        logic [N_DED-1:0] ded;
        logic [N_MC-1:0]  io_drv;
        logic [N_MC-1:0]  io;
    } clm_pins_t;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } clm_bus_req_t;

    // Whole state of the array
    typedef struct packed {
        clm_pins_t        s1;
        clm_pins_t        s2;
        logic [N_MC-1:0]  io_keep;
        logic [N_DED-1:0] ded_keep;
        logic [N_MC-1:0]  q;
        logic [N_MC-1:0]  fb;
        logic [N_MC-1:0]  fold;
        logic [N_MC-1:0]  clk_prev;
        logic [N_MC-1:0]  io_o;
        logic [N_MC-1:0]  io_oe;
        logic             keep_en;
        logic             stby_en;
        logic             fuse;
        logic [SIG_W-1:0] sig;
        logic [DATA_W-1:0] rdata;
        logic             stby;
    } clm_state_t;

endpackage

/* File: rtl/clm_array.sv */
/*
 * Array of 64 configurable logic macrocells with global switch matrix,
 * foldback bus, cascade chains, pin keepers, standby detect, security fuse
 * and user signature.
 * Assumes configuration inputs stay constant while running, pins arrive
 * asynchronously, and the register master follows the one-cycle strobe port.
 */
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps

module clm_array
    import clm_pkg::*;
(
    input  wire logic                                 clk,
    input  wire logic                                 rst,
    input  wire clm_pkg::clm_mc_cfg_t [clm_pkg::N_MC-1:0] mc_cfg,
    input  wire clm_pkg::clm_glb_cfg_t                glb_cfg,
    input  wire clm_pkg::clm_pins_t                   pins,
    input  wire clm_pkg::clm_bus_req_t                bus,
    output logic [clm_pkg::N_MC-1:0]                  io_o,
    output logic [clm_pkg::N_MC-1:0]                  io_oe,
    output logic [clm_pkg::DATA_W-1:0]                rd_data,
    output logic                                      standby
);
    import clm_pkg::*;

    // ********************************
    // State
    // ********************************
    clm_state_t st_q;
    clm_state_t st_d;

    // ********************************
    // Pin view and global lines
    // ********************************
    logic [N_MC-1:0]      io_eff;
    logic [N_DED-1:0]     ded_eff;
    logic [N_GCLK-1:0]    gclk;
    logic [N_GOE-1:0]     goe;
    logic                 gclr;
    logic [N_GBUS-1:0]    gbus;
    logic [N_BLK-1:0][N_SW-1:0] sw;

    // Per macrocell results
    logic [N_MC-1:0]      sum_w;
    logic [N_MC-1:0]      xr_w;
    logic [N_MC-1:0]      q_nx;
    logic [N_MC-1:0]      clk_now;
    logic [N_MC-1:0]      oe_nx;
    logic [N_MC-1:0]      fold_nx;

    // keeper hold
    // Own drive also counts: a pin we drive reads back our level
    always_comb begin
        for (int i = 0; i < N_MC; i++) begin
            if (st_q.keep_en && !st_q.s2.io_drv[i] && !st_q.io_oe[i]) begin
                io_eff[i] = st_q.io_keep[i];
            end else begin
                io_eff[i] = st_q.s2.io[i];
            end
        end
        for (int i = 0; i < N_DED; i++) begin
            if (st_q.keep_en && !st_q.s2.ded_drv[i]) begin
                ded_eff[i] = st_q.ded_keep[i];
            end else begin
                ded_eff[i] = st_q.s2.ded[i];
            end
        end
    end

    always_comb begin
        for (int k = 0; k < N_GCLK; k++) begin
            gclk[k] = ded_eff[glb_cfg.gclk_src[k]];
        end
        for (int k = 0; k < N_GOE; k++) begin
            goe[k] = ded_eff[glb_cfg.oe_src[k]];
        end
        gclr = ded_eff[glb_cfg.clr_src];
    end

    // global bus and switch matrix
    // Feedback is the registered copy, which keeps the array free of loops
    always_comb begin
        gbus = {st_q.fb, io_eff, ded_eff};
        for (int b = 0; b < N_BLK; b++) begin
            for (int j = 0; j < N_SW; j++) begin
                if (glb_cfg.sw_sel[b][j] < 8'(N_GBUS)) begin
                    sw[b][j] = gbus[glb_cfg.sw_sel[b][j]];
                end else begin
                    sw[b][j] = 1'b0;
                end
            end
        end
    end

    // OR of all terms routed to one destination
    function automatic logic role(
        input logic [N_PT-1:0]          pt,
        input clm_pt_dest_t [N_PT-1:0]  dst,
        input clm_pt_dest_t             want
    );
        logic r;
        r = 1'b0;
        for (int k = 0; k < N_PT; k++) begin
            if (dst[k] == want) begin
                r = r | pt[k];
            end
        end
        return r;
    endfunction

    // ********************************
    // Macrocells
    // ********************************
    for (genvar i = 0; i < N_MC; i++) begin : g_mc
        localparam int BLK = i / MC_BLK;
        clm_mc_cfg_t      c;
        logic [N_LIT-1:0] lits;
        logic [N_PT-1:0]  pt;
        logic             cas_in;
        logic             x2;
        logic             din;
        logic             aux;
        logic             ce_ok;
        logic             upd;
        logic             ar;
        logic             ap;
        logic             nxt;

        assign c = mc_cfg[i];

        // term inputs
        // Regional part is the foldback of this block
        assign lits = {st_q.fold[BLK*MC_BLK +: MC_BLK], sw[BLK]};

        // product terms
        // A term with no literals is off, as the fitter leaves it
        always_comb begin
            for (int k = 0; k < N_PT; k++) begin
                pt[k] = (|(c.lit_pos[k] | c.lit_neg[k]))
                      & (&(~c.lit_pos[k] | lits))
                      & (&(~c.lit_neg[k] | ~lits));
            end
        end

        // cascade from previous cell in chain
        if (i % MC_BLK == 0) begin : g_head
            assign cas_in = 1'b0;
        end else begin : g_link
            assign cas_in = sum_w[i-1];
        end

        assign sum_w[i] = role(pt, c.dest, PT_SUM) | (c.cas_en & cas_in);
        assign aux      = role(pt, c.dest, PT_AUX);

        always_comb begin
            case (c.xor_sel)
                XOR_PT:   x2 = role(pt, c.dest, PT_XOR);
                XOR_ONE:  x2 = 1'b1;
                default:  x2 = 1'b0;
            endcase
        end
        assign xr_w[i] = sum_w[i] ^ x2;

        always_comb begin
            case (c.din_sel)
                DIN_PT:   din = role(pt, c.dest, PT_DATA);
                DIN_PIN:  din = io_eff[i];
                default:  din = xr_w[i];
            endcase
        end

        always_comb begin
            case (c.clk_sel)
                CK_G0:   clk_now[i] = gclk[0];
                CK_G1:   clk_now[i] = gclk[1];
                CK_G2:   clk_now[i] = gclk[2];
                default: clk_now[i] = role(pt, c.dest, PT_CLK);
            endcase
        end

        // enable only with a global clock
        assign ce_ok = !(c.ce_en && c.clk_sel != CK_PT) || role(pt, c.dest, PT_CE);

        // latch is open while clock is high
        assign upd = (c.ff_type == FF_LATCH) ? (clk_now[i] & ce_ok)
                   : (clk_now[i] & ~st_q.clk_prev[i] & ce_ok);

        // storage types
        // JK and SR take J or S from data and K or R from the aux term
        always_comb begin
            case (c.ff_type)
                FF_T:    nxt = st_q.q[i] ^ din;
                FF_JK:   nxt = (din & ~st_q.q[i]) | (~aux & st_q.q[i]);
                FF_SR:   nxt = (din & ~aux) | (~aux & st_q.q[i]) | (din & st_q.q[i]);
                default: nxt = din;
            endcase
        end

        always_comb begin
            case (c.ar_sel)
                AR_GCLR: ar = gclr;
                AR_PT:   ar = role(pt, c.dest, PT_RST);
                AR_OR:   ar = gclr | role(pt, c.dest, PT_RST);
                default: ar = 1'b0;
            endcase
        end

        assign ap = c.ap_en & role(pt, c.dest, PT_PRE);

        // Reset wins over preset when both are active
        always_comb begin
            if (ar) begin
                q_nx[i] = 1'b0;
            end else if (ap) begin
                q_nx[i] = 1'b1;
            end else if (upd) begin
                q_nx[i] = nxt;
            end else begin
                q_nx[i] = st_q.q[i];
            end
        end

        always_comb begin
            case (c.oe_sel)
                OE_ON:   oe_nx[i] = 1'b1;
                OE_G0:   oe_nx[i] = goe[0];
                OE_G1:   oe_nx[i] = goe[1];
                OE_PIN:  oe_nx[i] = io_eff[c.oe_pin];
                OE_PT:   oe_nx[i] = role(pt, c.dest, PT_OE);
                default: oe_nx[i] = 1'b0;
            endcase
        end

        always_comb begin
            if (c.fold_sel < 3'(N_PT)) begin
                fold_nx[i] = ~pt[c.fold_sel];
            end else begin
                fold_nx[i] = 1'b1;
            end
        end
    end

    // ********************************
    // Next state
    // ********************************
    always_comb begin
        st_d = st_q;

        // Two-stage pin synchroniser
        st_d.s1 = pins;
        st_d.s2 = st_q.s1;

        st_d.io_keep  = io_eff;
        st_d.ded_keep = ded_eff;

        st_d.q        = q_nx;
        st_d.clk_prev = clk_now;
        st_d.fold     = fold_nx;

        for (int i = 0; i < N_MC; i++) begin
            st_d.fb[i]   = mc_cfg[i].fb_reg ? q_nx[i] : xr_w[i];
            st_d.io_o[i] = mc_cfg[i].out_reg ? q_nx[i] : xr_w[i];
        end

        st_d.io_oe = oe_nx;

        st_d.stby = st_q.stby_en
                  & (io_eff == st_q.io_keep)
                  & (ded_eff == st_q.ded_keep)
                  & (q_nx == st_q.q)
                  & (fold_nx == st_q.fold);

        // Control and signature writes
        if (bus.wr) begin
            case (bus.addr)
                REG_CTRL: begin
                    st_d.keep_en = bus.wdata[CTRL_KEEP];
                    st_d.stby_en = bus.wdata[CTRL_STBY];
                    st_d.fuse    = st_q.fuse | bus.wdata[CTRL_FUSE];
                end
                REG_SIG: begin
                    if (!st_q.fuse) begin
                        st_d.sig = bus.wdata[SIG_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Read data stands one cycle only
        st_d.rdata = '0;
        if (bus.rd) begin
            case (bus.addr)
                REG_CTRL: begin
                    st_d.rdata[CTRL_KEEP] = st_q.keep_en;
                    st_d.rdata[CTRL_STBY] = st_q.stby_en;
                    st_d.rdata[CTRL_FUSE] = st_q.fuse;
                end
                REG_SIG: st_d.rdata[SIG_W-1:0] = st_q.sig;
                REG_STAT: begin
                    st_d.rdata[STAT_STBY] = st_q.stby;
                    st_d.rdata[STAT_FUSE] = st_q.fuse;
                end
                REG_STATE_LO: begin
                    if (!st_q.fuse) begin
                        st_d.rdata = st_q.q[DATA_W-1:0];
                    end
                end
                REG_STATE_HI: begin
                    if (!st_q.fuse) begin
                        st_d.rdata = st_q.q[N_MC-1:DATA_W];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ********************************
    // State register
    // ********************************
    // Signature reset value kept by name
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q     <= '0;
            st_q.sig <= SIG_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flops
    assign io_o    = st_q.io_o;
    assign io_oe   = st_q.io_oe;
    assign rd_data = st_q.rdata;
    assign standby = st_q.stby;

endmodule

/* File: verification/clm_pin_model.sv */
/*
 * Pin model: outside circuitry on the I/O and dedicated input pins.
 * Assumes the bench sets drive values; a released pin shows the inverse
 * of its last driven level, so a missing keeper cannot hide.
 */
`timescale 1ns/1ps

module clm_pin_model
    import clm_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic [clm_pkg::N_MC-1:0]  io_o,
    input  wire logic [clm_pkg::N_MC-1:0]  io_oe,
    input  wire logic [clm_pkg::N_MC-1:0]  ext_val,
    input  wire logic [clm_pkg::N_MC-1:0]  ext_en,
    input  wire logic [clm_pkg::N_DED-1:0] ded_val,
    output clm_pkg::clm_pins_t             pins
);
    import clm_pkg::*;

    logic [N_MC-1:0] lvl;
    logic [N_MC-1:0] last_q;
    logic [N_MC-1:0] drv;

    // Device drive wins, then outside drive, else inverted last level
    assign drv  = io_oe | ext_en;
    assign lvl  = (io_oe & io_o) | (~io_oe & ext_en & ext_val) | (~drv & ~last_q);
    // Dedicated pins are always driven from outside
    assign pins = '{ded_drv: '1, ded: ded_val, io_drv: ext_en, io: lvl};

    // Last level that any party drove
    always_ff @(posedge clk) begin
        if (rst) begin
            last_q <= '0;
        end else begin
            last_q <= (drv & lvl) | (~drv & last_q);
        end
    end
endmodule

/* File: verification/clm_array_props.sv */
/*
 * Checker for the macrocell array top: register port, standby, enables.
 * Assumes static configuration and the one-cycle strobe register port.
 */
`timescale 1ns/1ps

module clm_array_props
    import clm_pkg::*;
(
    input wire logic                                     clk,
    input wire logic                                     rst,
    input wire clm_pkg::clm_mc_cfg_t [clm_pkg::N_MC-1:0] mc_cfg,
    input wire clm_pkg::clm_glb_cfg_t                    glb_cfg,
    input wire clm_pkg::clm_pins_t                       pins,
    input wire clm_pkg::clm_bus_req_t                    bus,
    input wire logic [clm_pkg::N_MC-1:0]                 io_o,
    input wire logic [clm_pkg::N_MC-1:0]                 io_oe,
    input wire logic [clm_pkg::DATA_W-1:0]               rd_data,
    input wire logic                                     standby
);
    import clm_pkg::*;

    logic [N_MC-1:0] off_mask;
    logic [N_MC-1:0] on_mask;
    logic            unmapped;

    // Enable modes decoded from the static configuration
    always_comb begin
        for (int i = 0; i < N_MC; i++) begin
            off_mask[i] = (mc_cfg[i].oe_sel == OE_OFF);
            on_mask[i]  = (mc_cfg[i].oe_sel == OE_ON);
        end
    end

    // Addresses outside the register map
    assign unmapped = !(bus.addr inside {REG_CTRL, REG_SIG, REG_STAT, REG_STATE_LO, REG_STATE_HI});

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ********************************
    // Properties
    // ********************************
    a_reset_quiet: assert property ($fell(rst) |-> io_o == '0 && io_oe == '0 && rd_data == '0 && !standby)
        else $error("outputs not cleared by reset");
    a_oe_off_held: assert property ((io_oe & off_mask) == '0)
        else $error("disabled buffer drives its pin");
    a_oe_on_held: assert property (1'b1 |=> (~io_oe & on_mask) == '0)
        else $error("always-on buffer not driving");
    a_rdata_idle: assert property (!bus.rd |=> rd_data == '0)
        else $error("read data without a read");
    a_unmapped_zero: assert property (bus.rd && unmapped |=> rd_data == '0)
        else $error("unmapped read not zero");
    a_sig_width: assert property (bus.rd && bus.addr == REG_SIG |=> rd_data[31:16] == '0)
        else $error("signature wider than sixteen bits");
    a_stat_standby: assert property (bus.rd && bus.addr == REG_STAT |=>
        rd_data[STAT_STBY] == $past(standby) && rd_data[31:2] == '0)
        else $error("status does not match standby");
    a_standby_wake: assert property ($changed(pins.io) |-> ##[1:4] !standby)
        else $error("standby held through pin activity");

    // Main scenarios reached
    c_sig_read: cover property (bus.rd && bus.addr == REG_SIG);
    c_standby: cover property ($rose(standby));
    c_oe_pin: cover property ($rose(io_oe[8]));
endmodule

bind clm_array clm_array_props u_props (
    .clk(clk), .rst(rst), .mc_cfg(mc_cfg), .glb_cfg(glb_cfg), .pins(pins), .bus(bus),
    .io_o(io_o), .io_oe(io_oe), .rd_data(rd_data), .standby(standby)
);

/* File: verification/testbench.sv */
/*
 * Self-checking bench for the macrocell array: pins through the pin
 * model, registers through the strobe port.
 * Assumes the shared package and a 50 MHz clock.
 */
`timescale 1ns/1ps

module testbench;
    import clm_pkg::*;

    logic                   clk;
    logic                   rst;
    clm_mc_cfg_t [N_MC-1:0] cfg;
    clm_glb_cfg_t           glb;
    clm_pins_t              pins;
    clm_bus_req_t           bus_q;
    logic [N_MC-1:0]        io_o;
    logic [N_MC-1:0]        io_oe;
    logic [N_MC-1:0]        ext_val;
    logic [N_MC-1:0]        ext_en;
    logic [N_DED-1:0]       ded_val;
    logic [DATA_W-1:0]      rd_data;
    logic                   standby;
    logic                   wake;
    int                     mismatches;
    int                     compares;
    int                     cycles;
    int                     on_l[9]  = '{0, 1, 2, 3, 4, 5, 6, 9, 10};
    int                     reg_l[7] = '{3, 4, 5, 6, 10, 12, 13};

    clm_array dut (.clk(clk), .rst(rst), .mc_cfg(cfg), .glb_cfg(glb), .pins(pins), .bus(bus_q),
        .io_o(io_o), .io_oe(io_oe), .rd_data(rd_data), .standby(standby));
    clm_pin_model u_pins (.clk(clk), .rst(rst), .io_o(io_o), .io_oe(io_oe), .ext_val(ext_val),
        .ext_en(ext_en), .ded_val(ded_val), .pins(pins));

    // ********************************
    // Tasks
    // ********************************
    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // Long enough for the two-flop pin sync plus output register
    task settle;
        repeat (6) @(posedge clk);
        #1;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_q.addr  <= a;
        bus_q.wdata <= d;
        bus_q.wr    <= 1'b1;
        @(posedge clk);
        bus_q.wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
        @(posedge clk);
        bus_q.addr <= a;
        bus_q.rd   <= 1'b1;
        @(posedge clk);
        bus_q.rd   <= 1'b0;
        #1;
        chk(n, rd_data & m, e);
    endtask

    task pin(input int i, input logic v);
        @(posedge clk);
        ext_val[i] <= v;
        settle();
    endtask

    task dpin(input int i, input logic v);
        @(posedge clk);
        ded_val[i] <= v;
        settle();
    endtask

    task lit(input int m, input int t, input int s, input clm_pt_dest_t d);
        cfg[m].lit_pos[t][s] = 1'b1;
        cfg[m].dest[t]       = d;
    endtask

    task test_done;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            test_done();
        end
    end

    // ********************************
    // Sequence
    // ********************************
    initial begin
        rst        = 1'b1;
        bus_q      = '0;
        ext_val    = '0;
        ext_en     = 64'h0000_0f00_0000_0000;
        ded_val    = '0;
        mismatches = 0;
        compares   = 0;
        cycles     = 0;
        glb        = '0;
        // Inputs on pins 40..43 reach switch slots 0..3 of block 0
        for (int i = 0; i < N_MC; i++) begin
            cfg[i]         = '0;
            cfg[i].oe_sel  = OE_OFF;
            cfg[i].ar_sel  = AR_OFF;
            cfg[i].xor_sel = XOR_ZERO;
        end
        for (int s = 0; s < 4; s++) begin
            glb.sw_sel[0][s] = 8'(GBUS_IO + 40 + s);
        end
        glb.clr_src   = 2'h1;
        glb.oe_src[0] = 2'h2;
        // Slot 4 carries the buried feedback of cell 2
        glb.sw_sel[0][4] = 8'(GBUS_FB + 2);
        lit(0, 0, 1, PT_SUM);
        lit(1, 0, 1, PT_SUM);
        lit(2, 0, 1, PT_SUM);
        lit(2, 1, 2, PT_SUM);
        lit(3, 0, 0, PT_SUM);
        lit(4, 0, 0, PT_SUM);
        lit(4, 1, 3, PT_CE);
        lit(6, 0, 0, PT_SUM);
        lit(7, 0, 1, PT_OE);
        lit(8, 0, 2, PT_SUM);
        lit(9, 0, 3, PT_SUM);
        lit(10, 0, 1, PT_DATA);
        lit(12, 0, 0, PT_SUM);
        lit(12, 1, 3, PT_AUX);
        lit(13, 0, 3, PT_PRE);
        lit(14, 0, 40, PT_SUM);
        lit(15, 0, 4, PT_SUM);
        foreach (on_l[k]) cfg[on_l[k]].oe_sel = OE_ON;
        foreach (reg_l[k]) cfg[reg_l[k]].out_reg = 1'b1;
        cfg[1].xor_sel  = XOR_ONE;
        cfg[5].xor_sel  = XOR_ONE;
        cfg[7].xor_sel  = XOR_ONE;
        cfg[3].ar_sel   = AR_GCLR;
        cfg[4].ce_en    = 1'b1;
        cfg[5].ff_type  = FF_T;
        cfg[6].ff_type  = FF_LATCH;
        cfg[7].oe_sel   = OE_PT;
        cfg[8].oe_sel   = OE_G0;
        cfg[9].cas_en   = 1'b1;
        cfg[10].din_sel = DIN_PT;
        cfg[12].ff_type = FF_JK;
        cfg[13].ap_en   = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;

        rd(REG_CTRL, '1, '0, "ctrl");
        rd(REG_SIG, '1, '0, "sig");
        rd(REG_STAT, '1, '0, "stat");
        rd(8'h20, '1, '0, "unmapped");
        wr(REG_SIG, 32'h0000_5a3c);
        rd(REG_SIG, '1, 32'h5a3c, "sig");
        $display("test registers done");

        // Sum, polarity, cascade, enable, foldback and feedback over all input codes
        for (int v = 0; v < 8; v++) begin
            @(posedge clk);
            ext_val[43:41] <= v[2:0];
            settle();
            chk("comb", 32'({io_o[15:14], io_oe[7], io_o[9], io_o[2:0]}),
                32'({v[0] | v[1], ~v[0], v[0], v[1] | v[2], v[0] | v[1], ~v[0], v[0]}));
        end
        $display("test sum logic done");

        // Storage bits {13,12,10,6,5,4,3}: preset, JK, D, latch, T, D with enable, D with clear
        pin(43, 1'b0);
        pin(40, 1'b1);
        dpin(0, 1'b1);
        chk("ff", 32'({io_o[13:12], io_o[10], io_o[6:3]}), 32'h3d);
        pin(40, 1'b0);
        chk("ff", 32'({io_o[13:12], io_o[10], io_o[6:3]}), 32'h35);
        dpin(0, 1'b0);
        pin(40, 1'b1);
        chk("ff", 32'({io_o[13:12], io_o[10], io_o[6:3]}), 32'h35);
        pin(43, 1'b1);
        dpin(0, 1'b1);
        chk("ff", 32'({io_o[13:12], io_o[10], io_o[6:3]}), 32'h5b);
        dpin(0, 1'b0);
        dpin(1, 1'b1);
        chk("ff", 32'({io_o[13:12], io_o[10], io_o[6:3]}), 32'h5a);
        dpin(1, 1'b0);
        rd(REG_STATE_LO, 32'h18, 32'h10, "state");
        $display("test storage done");

        for (int v = 0; v < 2; v++) begin
            dpin(2, v[0]);
            chk("oe", 32'({io_oe[11], io_oe[8], io_oe[0]}), 32'({1'b0, v[0], 1'b1}));
        end
        $display("test enables done");

        // Released pin must keep its level, the model shows the inverse
        wr(REG_CTRL, 32'h1);
        @(posedge clk);
        ext_en[41] <= 1'b0;
        settle();
        chk("keep", 32'({io_oe[7], io_o[0]}), 32'h3);
        @(posedge clk);
        ext_en[41] <= 1'b1;
        settle();
        $display("test keeper done");

        wr(REG_CTRL, 32'h3);
        repeat (8) @(posedge clk);
        #1;
        chk("standby", 32'(standby), 32'h1);
        rd(REG_STAT, 32'h1, 32'h1, "stat");
        @(posedge clk);
        ext_val[42] <= ~ext_val[42];
        wake = 1'b0;
        repeat (5) begin
            @(posedge clk);
            #1;
            if (standby === 1'b0) wake = 1'b1;
        end
        chk("wake", 32'(wake), 32'h1);
        $display("test standby done");

        wr(REG_CTRL, 32'h7);
        rd(REG_STAT, 32'h2, 32'h2, "fuse");
        wr(REG_SIG, 32'h0000_1111);
        rd(REG_SIG, '1, 32'h5a3c, "sig");
        rd(REG_STATE_LO, '1, '0, "state");
        $display("test fuse done");
        test_done();
    end
endmodule
